// ==== design/rxctl_regs.svh ====
// Register offsets, message codes and protocol constants of the receiver controller
`ifndef RXCTL_REGS_SVH
`define RXCTL_REGS_SVH
// Software register offsets (byte addresses, one word each)
`define A_CTRL   8'h00
`define A_FREQ   8'h04
`define A_RATE   8'h08
`define A_GAIN   8'h0C
`define A_DADR   8'h10
`define A_DDAT   8'h14
`define A_DDAT4  8'h18
`define A_UPD    8'h1C
`define A_RUN    8'h20
`define A_FADR   8'h24
`define A_STAT   8'h28
`define A_FRB    8'h2C
`define A_FSIZE  8'h30
`define A_PSIZE  8'h34
`define A_SSIZE  8'h38
`define A_BLKS   8'h3C
// Message types in the top bits of header byte 1
`define T_SET    3'h0
`define T_REQ    3'h1
`define T_ACK    3'h3
`define T_DATA0  3'h4
`define T_DATA1  3'h5
// Control item codes
`define C_FREQ   16'h0020
`define C_RATE   16'h00B0
`define C_GAIN   16'h0038
`define C_RXST   16'h0018
`define C_UPD    16'h0300
`define C_UPDP   16'h0302
// Message lengths in bytes
`define L_FREQ   4'hA
`define L_GET    4'h5
`define L_RATE   4'h9
`define L_GAIN   4'h6
`define L_DSP    4'h9
`define L_UPD    4'hA
`define L_RXST   4'h8
`define L_FHDR   4'h6
`define BLK_LEN  14'h2002
// Field values
`define FREQ_MAX 32'h01FCA055
`define RATE_RST 32'h03F940AB
`define MULT_ONE 8'h01
`define CHAN_RX  8'h81
`define PW0      8'h5A
`define PW1      8'hFF
`define PW2      8'hA5
`define PW3      8'h00
`define G_0      8'h00
`define G_M10    8'hF6
`define G_M20    8'hEC
`define G_M30    8'hE2
`define UPD_STRT 2'h1
`define RX_IDLE  8'h01
`define RX_RUN   8'h02
`define CAP_ONE  8'h02
`endif

// ==== design/rxctl_pkg.sv ====
// Types shared by the receiver controller and its bench
package rxctl_pkg;
  // One byte on a valid-qualified byte stream
  typedef struct packed {
    logic       valid;
    logic [7:0] data;
  } beat_t;
  // One received sample word, {Q,I} or {0,R}
  typedef struct packed {
    logic        valid;
    logic [31:0] data;
  } sample_t;
  // Commands written to the control register
  typedef enum logic [3:0] {
    OP_NONE, OP_SET_FREQ, OP_GET_FREQ, OP_SET_RATE, OP_SET_GAIN, OP_GET_GAIN,
    OP_DSP, OP_UPD, OP_UPDP, OP_RXST, OP_FLASH
  } op_t;
  // Transmit engine states
  typedef enum logic [1:0] {TX_IDLE, TX_SEND, TX_FLASH, TX_WAIT_ACK} tx_state_t;
endpackage

// ==== design/receiver_control_message_handler.sv ====
// Host-side controller that builds receiver control messages and parses replies and data
`timescale 1ns/1ps
`default_nettype none
`include "rxctl_regs.svh"
module receiver_control_message_handler #(
  parameter int unsigned PAGE_BYTES = 256 // Flash page size used for programming blocks
) (
  input  wire logic               hclk,
  input  wire logic               hresetn,
  input  wire logic               hsel,
  input  wire logic [31:0]        haddr,
  input  wire logic [1:0]         htrans,
  input  wire logic               hwrite,
  input  wire logic [2:0]         hsize,
  input  wire logic [31:0]        hwdata,
  input  wire logic               hready,
  output logic                    hreadyout,
  output logic [31:0]             hrdata,
  output logic                    hresp,
  output var rxctl_pkg::beat_t    tx,
  input  wire logic               tx_ready,
  input  wire rxctl_pkg::beat_t   rx,
  input  wire rxctl_pkg::beat_t   fdata,
  output logic                    fdata_ready,
  output var rxctl_pkg::sample_t  sample
);
  // ==========================================================
  // State
  localparam logic [15:0] PAGE = 16'(PAGE_BYTES);
  localparam logic [12:0] FLEN = 13'(PAGE_BYTES + 6);

  typedef struct packed {
    logic                 hreadyout;   // Always ready: zero-wait slave
    logic [31:0]          hrdata;      // Read data for the data phase
    logic                 hresp;       // Always OKAY
    logic                 wr_pend;     // Write data phase pending
    logic [7:0]           wr_addr;     // Its offset
    rxctl_pkg::tx_state_t txs;         // Transmit engine state
    rxctl_pkg::beat_t     tx;          // Byte offered to the bridge
    logic [15:0][7:0]     msg;         // Message being sent
    logic [3:0]           len;         // Its length
    logic [3:0]           idx;         // Next byte to send
    logic [15:0]          page_cnt;    // Flash data bytes sent
    logic                 fready;      // Flash byte can be taken this cycle
    logic [31:0]          freq;        // Tuning frequency to send
    logic [31:0]          rate;        // Reference sample rate to send
    logic                 gain_mode;   // 0 fixed, 1 manual
    logic [7:0]           gain_val;    // Gain value byte
    logic [15:0]          dsp_addr;    // Down-converter register address
    logic [39:0]          dsp_data;    // Five setup data bytes
    logic [1:0]           upd_mode;    // Update mode command
    logic                 run;         // Capture run/stop
    logic                 oneshot;     // One-shot capture mode
    logic                 real_mode;   // Payload holds real samples
    logic [7:0]           nblocks;     // One-shot block count
    logic [31:0]          flash_addr;  // Target address of next block
    rxctl_pkg::op_t       last_op;     // Last command written
    logic                 refused;     // Last command was refused
    logic                 upd_started; // Update process running
    logic                 capturing;   // Device believed to be running
    logic                 ack_seen;    // An ack has arrived
    logic [7:0]           ack_code;    // Its value byte
    logic [31:0]          freq_rb;     // Frequency from last reply
    logic [31:0]          fsize;       // Flash size reply
    logic [31:0]          psize;       // Page size reply
    logic [31:0]          ssize;       // Sector size reply
    logic [15:0]          blocks;      // Data blocks received
    logic [13:0]          ridx;        // Byte index in incoming message
    logic [13:0]          rlen;        // Length of incoming message
    logic [2:0]           rtype;       // Type of incoming message
    logic [15:0]          rcode;       // Item code of incoming message
    logic [31:0]          win;         // Last four received bytes
    rxctl_pkg::sample_t   smp;         // Assembled sample
  } state_t;

  state_t         s_q;      // Registered state
  state_t         s_d;      // Next state
  logic           launch;   // Control register written
  rxctl_pkg::op_t op;       // Command written
  logic           bad;      // Command refused
  logic           ack_now;  // Ack byte arriving now
  logic           slot_free;// Transmit slot can take a byte
  logic [7:0]     b;        // Received byte
  logic [31:0]    nwin;     // Window with the new byte
  logic [13:0]    rlen_now; // Length known this cycle
  logic [31:0]    rdat;     // Read data being decoded
  logic [7:0]     a;        // Decoded offset

  // Fixed gain steps that the device accepts
  function automatic logic fixed_ok(input logic [7:0] v);
    fixed_ok = (v == `G_0) || (v == `G_M10) || (v == `G_M20) || (v == `G_M30);
  endfunction

  // ==========================================================
  // Next-state logic
  always_comb begin
    s_d = s_q;
    launch = 1'b0;
    op = rxctl_pkg::OP_NONE;
    bad = 1'b0;
    ack_now = 1'b0;
    rdat = 32'h0;
    a = s_q.wr_addr;
    b = rx.data;
    nwin = {rx.data, s_q.win[31:8]};
    rlen_now = s_q.rlen;
    slot_free = !s_q.tx.valid || tx_ready;
    s_d.smp.valid = 1'b0;
    s_d.wr_pend = 1'b0;
    // Address phase: reads answer in the very next cycle
    if (hsel && htrans[1] && hready) begin
      s_d.wr_pend = hwrite;
      s_d.wr_addr = haddr[7:0];
      if (haddr[7:0] == `A_CTRL) rdat = {28'h0, s_q.last_op};
      else if (haddr[7:0] == `A_FREQ) rdat = s_q.freq;
      else if (haddr[7:0] == `A_RATE) rdat = s_q.rate;
      else if (haddr[7:0] == `A_GAIN) rdat = {23'h0, s_q.gain_mode, s_q.gain_val};
      else if (haddr[7:0] == `A_DADR) rdat = {16'h0, s_q.dsp_addr};
      else if (haddr[7:0] == `A_DDAT) rdat = s_q.dsp_data[31:0];
      else if (haddr[7:0] == `A_DDAT4) rdat = {24'h0, s_q.dsp_data[39:32]};
      else if (haddr[7:0] == `A_UPD) rdat = {30'h0, s_q.upd_mode};
      else if (haddr[7:0] == `A_RUN) rdat = {16'h0, s_q.nblocks, 5'h0, s_q.real_mode, s_q.oneshot, s_q.run};
      else if (haddr[7:0] == `A_FADR) rdat = s_q.flash_addr;
      else if (haddr[7:0] == `A_STAT) rdat = {16'h0, s_q.ack_code, 3'h0, s_q.ack_seen, s_q.capturing,
                                              s_q.upd_started, s_q.refused, s_q.txs != rxctl_pkg::TX_IDLE};
      else if (haddr[7:0] == `A_FRB) rdat = s_q.freq_rb;
      else if (haddr[7:0] == `A_FSIZE) rdat = s_q.fsize;
      else if (haddr[7:0] == `A_PSIZE) rdat = s_q.psize;
      else if (haddr[7:0] == `A_SSIZE) rdat = s_q.ssize;
      else if (haddr[7:0] == `A_BLKS) rdat = {16'h0, s_q.blocks};
      s_d.hrdata = rdat;
    end
    // Write data phase
    if (s_q.wr_pend) begin
      if (a == `A_CTRL) begin
        launch = 1'b1;
        op = rxctl_pkg::op_t'(hwdata[3:0]);
      end
      else if (a == `A_FREQ) s_d.freq = hwdata;
      else if (a == `A_RATE) s_d.rate = hwdata;
      else if (a == `A_GAIN) {s_d.gain_mode, s_d.gain_val} = hwdata[8:0];
      else if (a == `A_DADR) s_d.dsp_addr = hwdata[15:0];
      else if (a == `A_DDAT) s_d.dsp_data[31:0] = hwdata;
      else if (a == `A_DDAT4) s_d.dsp_data[39:32] = hwdata[7:0];
      else if (a == `A_UPD) s_d.upd_mode = hwdata[1:0];
      else if (a == `A_RUN) {s_d.nblocks, s_d.real_mode, s_d.oneshot, s_d.run} =
                            {hwdata[15:8], hwdata[2:0]};
      else if (a == `A_FADR) s_d.flash_addr = hwdata;
      // Other offsets are read-only and writes to them are dropped
    end
    // Receive parser: header, item code, then body
    if (rx.valid) begin
      s_d.win = nwin;
      s_d.ridx = s_q.ridx + 14'h1;
      if (s_q.ridx == 14'h1) begin
        s_d.rtype = b[7:5];
        rlen_now = {1'b0, b[4:0], s_q.win[31:24]};
        if (b[7:5] == `T_DATA0 && rlen_now == 14'h0) rlen_now = `BLK_LEN;
        s_d.rlen = rlen_now;
      end
      else if (s_q.ridx >= 14'h2) begin
        if (s_q.ridx == 14'h2) s_d.rcode[7:0] = b;
        if (s_q.ridx == 14'h3) s_d.rcode[15:8] = b;
        case (s_q.rtype)
          `T_ACK: begin
            if (s_q.ridx == 14'h2) begin
              ack_now = 1'b1;
              s_d.ack_seen = 1'b1;
              s_d.ack_code = b;
            end
          end
          `T_SET: begin
            if (s_q.rcode == `C_FREQ && s_q.ridx == 14'h8) s_d.freq_rb = nwin;
            if (s_q.rcode == `C_UPDP && s_q.ridx == 14'h8) s_d.fsize = nwin;
            if (s_q.rcode == `C_UPDP && s_q.ridx == 14'hC) s_d.psize = nwin;
            if (s_q.rcode == `C_UPDP && s_q.ridx == 14'h10) s_d.ssize = nwin;
            // Stop echo or end of one-shot both mean the device is idle
            if (s_q.rcode == `C_RXST && s_q.ridx == 14'h5 && b == `RX_IDLE) s_d.capturing = 1'b0;
          end
          `T_DATA0: begin
            if (!s_q.real_mode && s_q.ridx[1:0] == 2'b01) begin
              s_d.smp.valid = 1'b1;
              s_d.smp.data = nwin;
            end
            if (s_q.real_mode && s_q.ridx[0]) begin
              s_d.smp.valid = 1'b1;
              s_d.smp.data = {16'h0, nwin[31:16]};
            end
            if (s_q.ridx + 14'h1 >= s_q.rlen) s_d.blocks = s_q.blocks + 16'h1;
          end
          default: ;
        endcase
      end
      // A message ends on its last byte; lengths below two end after the header
      if (s_q.ridx != 14'h0 && s_q.ridx + 14'h1 >= rlen_now) s_d.ridx = 14'h0;
    end
    // Command launch: build the whole message before sending any byte
    if (launch) begin
      s_d.last_op = op;
      bad = (s_q.txs != rxctl_pkg::TX_IDLE) || (op == rxctl_pkg::OP_NONE) || (op > rxctl_pkg::OP_FLASH);
      if (op == rxctl_pkg::OP_SET_FREQ && s_q.freq > `FREQ_MAX) bad = 1'b1;
      if (op == rxctl_pkg::OP_SET_GAIN && !s_q.gain_mode && !fixed_ok(s_q.gain_val)) bad = 1'b1;
      // Blocks outside an update would be dropped by the device anyway
      if (op == rxctl_pkg::OP_FLASH && !s_q.upd_started) bad = 1'b1;
      s_d.refused = bad;
      if (!bad) begin
        s_d.txs = rxctl_pkg::TX_SEND;
        s_d.idx = 4'h0;
        s_d.page_cnt = 16'h0;
        s_d.msg = '0;
        case (op)
          rxctl_pkg::OP_SET_FREQ: begin
            s_d.len = `L_FREQ;
            s_d.msg[3:2] = `C_FREQ;
            s_d.msg[8:5] = s_q.freq;
            s_d.msg[9] = `MULT_ONE;
          end
          rxctl_pkg::OP_GET_FREQ: begin
            s_d.len = `L_GET;
            s_d.msg[3:2] = `C_FREQ;
          end
          rxctl_pkg::OP_SET_RATE: begin
            s_d.len = `L_RATE;
            s_d.msg[3:2] = `C_RATE;
            s_d.msg[8:5] = s_q.rate;
          end
          rxctl_pkg::OP_SET_GAIN: begin
            s_d.len = `L_GAIN;
            s_d.msg[3:2] = `C_GAIN;
            s_d.msg[4] = {7'h0, s_q.gain_mode};
            s_d.msg[5] = s_q.gain_val;
          end
          rxctl_pkg::OP_GET_GAIN: begin
            s_d.len = `L_GET;
            s_d.msg[3:2] = `C_GAIN;
            s_d.msg[4] = {7'h0, s_q.gain_mode};
          end
          rxctl_pkg::OP_DSP: begin
            s_d.len = `L_DSP;
            s_d.msg[3:2] = s_q.dsp_addr;
            s_d.msg[8:4] = s_q.dsp_data;
          end
          rxctl_pkg::OP_UPD: begin
            s_d.len = `L_UPD;
            s_d.msg[3:2] = `C_UPD;
            s_d.msg[5] = {6'h0, s_q.upd_mode};
            s_d.msg[9:6] = {`PW3, `PW2, `PW1, `PW0};
            s_d.upd_started = (s_q.upd_mode == `UPD_STRT);
          end
          rxctl_pkg::OP_UPDP: begin
            s_d.len = `L_GET;
            s_d.msg[3:2] = `C_UPDP;
          end
          rxctl_pkg::OP_RXST: begin
            s_d.len = `L_RXST;
            s_d.msg[3:2] = `C_RXST;
            s_d.msg[4] = `CHAN_RX;
            s_d.msg[5] = s_q.run ? `RX_RUN : `RX_IDLE;
            s_d.msg[6] = s_q.oneshot ? `CAP_ONE : 8'h00;
            s_d.msg[7] = s_q.nblocks;
            s_d.capturing = s_q.run;
          end
          default: begin
            s_d.len = `L_FHDR;
            s_d.msg[5:2] = s_q.flash_addr;
          end
        endcase
        // Header: length and type; the flash block header covers the page that follows
        case (op)
          rxctl_pkg::OP_GET_FREQ, rxctl_pkg::OP_GET_GAIN, rxctl_pkg::OP_UPDP:
            s_d.msg[1:0] = {`T_REQ, 9'h0, s_d.len};
          rxctl_pkg::OP_DSP: s_d.msg[1:0] = {`T_DATA1, 9'h0, s_d.len};
          rxctl_pkg::OP_FLASH: s_d.msg[1:0] = {`T_DATA0, FLEN};
          default: s_d.msg[1:0] = {`T_SET, 9'h0, s_d.len};
        endcase
      end
    end
    // Transmit engine
    case (s_q.txs)
      rxctl_pkg::TX_SEND: begin
        if (slot_free) begin
          if (s_q.idx < s_q.len) begin
            s_d.tx.valid = 1'b1;
            s_d.tx.data = s_q.msg[s_q.idx];
            s_d.idx = s_q.idx + 4'h1;
          end
          else begin
            s_d.tx.valid = 1'b0;
            if (s_q.last_op == rxctl_pkg::OP_FLASH) s_d.txs = rxctl_pkg::TX_FLASH;
            else if (s_q.last_op == rxctl_pkg::OP_DSP) s_d.txs = rxctl_pkg::TX_WAIT_ACK;
            else s_d.txs = rxctl_pkg::TX_IDLE;
          end
        end
      end
      rxctl_pkg::TX_FLASH: begin
        // Half rate: a byte is taken only into an empty slot, so none is ever dropped
        if (slot_free) s_d.tx.valid = 1'b0;
        if (s_q.fready && fdata.valid) begin
          s_d.tx.valid = 1'b1;
          s_d.tx.data = fdata.data;
          s_d.page_cnt = s_q.page_cnt + 16'h1;
        end
        else if (s_q.page_cnt == PAGE && slot_free) s_d.txs = rxctl_pkg::TX_WAIT_ACK;
      end
      rxctl_pkg::TX_WAIT_ACK: begin
        if (ack_now) s_d.txs = rxctl_pkg::TX_IDLE;
      end
      default: ;
    endcase
    s_d.fready = (s_d.txs == rxctl_pkg::TX_FLASH) && (s_d.page_cnt < PAGE) && !s_d.tx.valid;
  end

  // ==========================================================
  // State register
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      s_q <= '0;
      s_q.hreadyout <= 1'b1;
      s_q.rate <= `RATE_RST;
    end
    else begin
      s_q <= s_d;
    end
  end

  assign hreadyout   = s_q.hreadyout;
  assign hrdata      = s_q.hrdata;
  assign hresp       = s_q.hresp;
  assign tx          = s_q.tx;
  assign fdata_ready = s_q.fready;
  assign sample      = s_q.smp;

  // ==========================================================
  // Assertions
  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);

  a_freq_range: assert property (launch && op == rxctl_pkg::OP_SET_FREQ && s_q.freq > `FREQ_MAX |=>
    s_q.refused && !(s_q.txs == rxctl_pkg::TX_SEND && s_q.idx == 4'h0))
    else $error("Out-of-range frequency was sent");
  a_mult_one: assert property (launch && !bad && op == rxctl_pkg::OP_SET_FREQ |=>
    s_q.msg[9] == `MULT_ONE && s_q.len == `L_FREQ && s_q.msg[8:5] == $past(s_q.freq))
    else $error("Frequency message malformed");
  a_gain_fixed: assert property (launch && op == rxctl_pkg::OP_SET_GAIN && !s_q.gain_mode &&
    !fixed_ok(s_q.gain_val) |=> s_q.refused) else $error("Invalid fixed gain was accepted");
  a_gain_layout: assert property (launch && !bad && op == rxctl_pkg::OP_SET_GAIN |=>
    s_q.msg[4][0] == $past(s_q.gain_mode) && s_q.len == `L_GAIN) else $error("Gain message malformed");
  a_password: assert property (launch && !bad && op == rxctl_pkg::OP_UPD |=>
    s_q.msg[9:6] == {`PW3, `PW2, `PW1, `PW0}) else $error("Update password missing");
  a_dsp_len: assert property (launch && !bad && op == rxctl_pkg::OP_DSP |=>
    s_q.len == `L_DSP && s_q.msg[1][7:5] == `T_DATA1) else $error("Setup message malformed");
  a_ack_wait: assert property (s_q.txs == rxctl_pkg::TX_WAIT_ACK && !ack_now |=>
    s_q.txs == rxctl_pkg::TX_WAIT_ACK && !s_q.tx.valid) else $error("Left ack wait without ack");
  a_page_bound: assert property (s_q.txs == rxctl_pkg::TX_FLASH |-> s_q.page_cnt <= PAGE)
    else $error("Flash block longer than a page");
  a_tx_hold: assert property (s_q.tx.valid && !tx_ready |=> s_q.tx.valid && $stable(s_q.tx.data))
    else $error("Byte withdrawn before acceptance");
  a_flash_gate: assert property (launch && op == rxctl_pkg::OP_FLASH && !s_q.upd_started |=> s_q.refused)
    else $error("Flash block sent outside an update");

  c_freq_set: cover property (launch && !bad && op == rxctl_pkg::OP_SET_FREQ ##[1:40] !s_q.tx.valid);
  c_block_acked: cover property (s_q.txs == rxctl_pkg::TX_WAIT_ACK && ack_now && s_q.last_op == rxctl_pkg::OP_FLASH);
  c_sample: cover property (s_q.smp.valid && !s_q.real_mode);
  c_oneshot_end: cover property (s_q.capturing ##1 !s_q.capturing);
endmodule
`default_nettype wire

// ==== testbench/rx_device_model.sv ====
// Device-side model: echoes settings, acks setups and flash blocks, streams samples
`timescale 1ns/1ps
`default_nettype none
module rx_device_model (
  input  wire logic             clk,
  input  wire logic             rst_n,
  input  wire rxctl_pkg::beat_t tx,
  output var logic              tx_ready,
  output var rxctl_pkg::beat_t  rx
);
  logic [7:0] m [0:15]; // Head of the message being taken
  logic [7:0] oq [$];   // Reply bytes waiting for the link
  logic [2:0] st;       // Stall phase counter
  int         n;        // Bytes taken so far
  int         len;      // Length from the header
  // ==========
  // Take host bytes, queue replies, send one reply byte per cycle
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      n = 0;
      oq.delete();
      st <= 3'h0;
      tx_ready <= 1'b0;
      rx <= '0;
    end else begin
      st <= st + 3'h1;
      // One stall in eight proves the controller holds its byte
      tx_ready <= (st != 3'h3);
      if (tx.valid && tx_ready) begin
        if (n < 16) m[n] = tx.data;
        n++;
        len = (n > 1) ? {m[1][4:0], m[0]} : 0;
        if (n == len) begin
          n = 0;
          case (m[1][7:5])
            3'h0: begin
              for (int i = 0; i < len; i++) oq.push_back(m[i]);
              if (m[2] == 8'h18 && m[5] == 8'h02 && m[6] == 8'h02) begin
                for (int b = 0; b < 8192 * m[7]; b++) begin
                  if (b % 8192 == 0) oq = {oq, 8'h00, 8'h80};
                  oq.push_back(8'(b[7:0] + b[12:8]));
                end
                oq = {oq, 8'h08, 8'h00, 8'h18, 8'h00, 8'h81, 8'h01, 8'h02, m[7]};
              end
            end
            // Parameter request: flash, page and sector sizes, each low byte first
            3'h1: if (m[2] == 8'h02 && m[3] == 8'h03)
              oq = {oq, 8'h11, 8'h00, 8'h02, 8'h03, 8'h00, 8'h00, 8'h00, 8'h04, 8'h00, 8'h08, 8'h00, 8'h00,
                    8'h00, 8'h00, 8'h10, 8'h00, 8'h00};
            3'h4: oq = {oq, 8'h03, 8'h60, 8'h00};
            3'h5: oq = {oq, 8'h03, 8'h60, 8'h01};
            default: ;
          endcase
        end
      end
      // Released line inverts its data each idle cycle, showing the inverse of the last byte and the byte itself in turn
      if (oq.size() > 0) rx <= {1'b1, oq.pop_front()};
      else rx <= {1'b0, ~rx.data};
    end
  end
endmodule
`default_nettype wire

// ==== testbench/receiver_control_message_handler_bench.sv ====
// Bench for the receiver controller: register traffic, message bytes and samples
`timescale 1ns/1ps
`default_nettype none
module receiver_control_message_handler_bench;
  localparam int PB = 8; // Short page keeps flash blocks brief
  logic hclk = 1'b0, hresetn = 1'b0, hwrite = 1'b0, hreadyout, hresp, tx_ready, fdata_ready;
  logic [1:0] htrans = 2'h0;
  logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata, rd, seed = 32'h9926;
  rxctl_pkg::beat_t tx, rx, fdata = 9'h126;
  rxctl_pkg::sample_t sample;
  logic [7:0] txq [$];  // Expected bytes toward the device
  logic [31:0] smq [$]; // Expected sample words
  logic [8:0] gv [5] = '{9'h000, 9'h0F6, 9'h0EC, 9'h0E2, 9'h1BF}; // Gain mode and value
  int fail_count = 0, n_checks = 0;
  always #2.5 hclk = ~hclk;
  receiver_control_message_handler #(.PAGE_BYTES(PB)) dut_u (.hclk(hclk), .hresetn(hresetn),
    .hsel(1'b1), .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata),
    .hready(hreadyout), .hreadyout(hreadyout), .hrdata(hrdata), .hresp(hresp), .tx(tx),
    .tx_ready(tx_ready), .rx(rx), .fdata(fdata), .fdata_ready(fdata_ready), .sample(sample));
  rx_device_model dev_u (.clk(hclk), .rst_n(hresetn), .tx(tx), .tx_ready(tx_ready), .rx(rx));
  // ==========
  // Helpers
  function automatic logic [31:0] xs(input logic [31:0] s);
    s = s ^ (s << 13);
    s = s ^ (s >> 17);
    return s ^ (s << 5);
  endfunction
  function automatic logic [7:0] pb(input int k);
    return 8'(k[7:0] + k[12:8]);
  endfunction
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    n_checks++;
    if (g !== e) begin
      fail_count++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask
  task summarize;
    $display("checks=%0d mismatches=%0d", n_checks, fail_count);
    if (fail_count == 0 && n_checks > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  // One single AHB transfer; waits on hready, never on a fixed count
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
    haddr <= {24'h0, a};
    hwrite <= w;
    htrans <= 2'h2;
    @(posedge hclk);
    while (hreadyout !== 1'b1) @(posedge hclk);
    htrans <= 2'h0;
    hwdata <= d;
    @(posedge hclk);
    while (hreadyout !== 1'b1) @(posedge hclk);
    rd = hrdata;
  endtask
  task automatic rdchk(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e);
    bus(1'b0, a, 32'h0);
    chk(rd & m, e);
  endtask
  // Poll status until the masked bits clear
  task automatic wt(input logic [31:0] m);
    for (int k = 0; k < 20000; k++) begin
      bus(1'b0, 8'h28, 32'h0);
      if ((rd & m) === 32'h0) return;
    end
    chk(rd & m, 32'h0);
  endtask
  // Note the message bytes, launch the command, wait until done
  task automatic op(input logic [3:0] c, input logic [79:0] v, input int n);
    for (int i = n - 1; i >= 0; i--) txq.push_back(v[8*i+:8]);
    bus(1'b1, 8'h00, {28'h0, c});
    wt(32'h1);
  endtask
  // ==========
  // Monitor: each result meets the oldest note; flash bytes are noted as fed
  always @(posedge hclk) begin
    if (tx.valid && tx_ready) chk(tx.data, txq.size() > 0 ? txq.pop_front() : 'x);
    if (sample.valid) chk(sample.data, smq.size() > 0 ? smq.pop_front() : 'x);
    if (fdata.valid && fdata_ready) begin
      txq.push_back(fdata.data);
      seed = xs(seed);
      fdata <= {1'b1, seed[7:0]};
    end
  end
  // Watchdog well beyond the expected run
  initial begin
    #400000;
    fail_count++;
    summarize();
  end
  initial begin
    repeat (5) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    rdchk(8'h08, '1, 32'h03F940AB);
    rdchk(8'h40, '1, 32'h0);
    bus(1'b1, 8'h04, 32'h00D5C690);
    op(4'h1, 80'h0A00200000_90C6D50001, 10);
    bus(1'b1, 8'h04, 32'h01FCA056);
    bus(1'b1, 8'h00, 32'h1);
    rdchk(8'h28, 32'h2, 32'h2);
    seed = xs(seed);
    bus(1'b1, 8'h08, seed);
    op(4'h3, {40'h0900B00000, seed[7:0], seed[15:8], seed[23:16], seed[31:24]}, 9);
    rdchk(8'h2C, '1, 32'h00D5C690);
    foreach (gv[i]) begin
      bus(1'b1, 8'h0C, {23'h0, gv[i]});
      op(4'h4, {32'h06003800, 7'h0, gv[i]}, 6);
    end
    bus(1'b1, 8'h0C, 32'h5);
    bus(1'b1, 8'h00, 32'h4);
    rdchk(8'h28, 32'h2, 32'h2);
    op(4'h2, 80'h0520200000, 5);
    op(4'h5, 80'h0520380000, 5);
    op(4'h8, 80'h0520020300, 5);
    bus(1'b1, 8'h10, 32'h0302);
    bus(1'b1, 8'h14, 32'h3456789A);
    bus(1'b1, 8'h18, 32'h12);
    op(4'h6, 80'h09A002039A78563412, 9);
    rdchk(8'h28, 32'hFF10, 32'h0110);
    rdchk(8'h30, '1, 32'h00040000);
    rdchk(8'h34, '1, 32'h00000008);
    rdchk(8'h38, '1, 32'h00001000);
    bus(1'b1, 8'h00, 32'hA);
    rdchk(8'h28, 32'h2, 32'h2);
    for (int u = 2; u < 6; u++) begin
      bus(1'b1, 8'h1C, u % 4);
      op(4'h7, {40'h0A00000300, 8'(u % 4), 32'h5AFFA500}, 10);
    end
    rdchk(8'h28, 32'h4, 32'h4);
    bus(1'b1, 8'h24, 32'h12345);
    op(4'hA, 80'h0E8045230100, 6);
    rdchk(8'h28, 32'hFF10, 32'h0010);
    for (int r = 3; r < 8; r += 4) begin
      for (int k = 0; k < 8192; k += (r == 7) ? 2 : 4)
        smq.push_back(r == 7 ? {16'h0, pb(k+1), pb(k)} : {pb(k+3), pb(k+2), pb(k+1), pb(k)});
      bus(1'b1, 8'h20, 32'h100 | r);
      op(4'h9, 80'h0800180081020201, 8);
      for (int k = 0; k < 20000 && smq.size() > 0; k++) @(posedge hclk);
      wt(32'h8);
      rdchk(8'h3C, '1, (r + 1) / 4);
    end
    summarize();
  end
endmodule
`default_nettype wire
